// [osr_regs.sv]
`timescale 1ns/1ns
`include "osr_cfg.svh"
// What this block does
// - Twelve 8-bit registers, all reachable over the serial bus.
// - Slave works in standard, fast and high-speed bus modes.
// - Answers only to the fixed 7-bit address 0010011.
// - Address byte LSB selects direction: 26h write, 27h read.
// - Register addresses 80h to 8Bh map to registers zero to eleven.
// - Command byte: lock reads 1, two ready flags, two start bits, rest zero.
// - Ready flag sets on completion, clears when its low result byte is read.
// - Light start runs one conversion, result into registers five and six.
// - Near start runs one conversion, result into registers seven and eight.
// - Both start bits in one write start both conversions together.
// - Register 81h is read-only product and revision identifier.
// - Register 82h exists but controls nothing.
// - Low six bits of 83h: emitter code, 10 mA steps, reset 2.
// - Emitter codes above 20 drive at most 200 mA.
// - Top two bits of 83h are read-only trim program tag.
module osr_regs #(
	parameter logic [7:0] PART_REV = 8'h35, // Arbitrary id value
	parameter logic [1:0] TRIM_TAG = 2'h1 // Arbitrary trim tag
) (
	input wire logic sys_clk_i, // 50 MHz clock
	input wire logic rst_i, // Sync reset, active high
	input wire logic ce_i, // Clock enable, freezes all
	input wire logic scl_i, // Bus clock level
	input wire logic sda_i, // Bus data level
	output logic sda_o, // Bus data drive value
	output logic sda_oe_o, // High while pulling data low
	input wire logic light_done_i, // Light conversion done
	input wire logic [15:0] light_data_i, // Light result
	input wire logic near_done_i, // Near conversion done
	input wire logic [15:0] near_data_i, // Near result
	output logic light_single_shot_o, // Light start pulse
	output logic near_single_shot_o, // Near start pulse
	output logic [5:0] led_drive_o, // Clamped emitter code
	output logic [7:0] light_param_o // Light parameter byte
);

	osr_pkg::osr_state_s s;
	osr_pkg::osr_state_s n;
	logic rise;
	logic fall;
	logic start_c;
	logic stop_c;
	logic wr_en;
	logic rd_ld;
	logic [7:0] rd;
	logic [7:0] cmd_rd;
	logic [7:0] id_rd;
	logic [7:0] unused_rd;
	logic [7:0] led_rd;

	// Read view of one register address
	function automatic logic [7:0] rd_byte(input logic [7:0] a, input osr_pkg::osr_state_s st);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`OSR_ADR_CMD: v = {1'b1, st.lrdy, st.nrdy, 5'h00};
			`OSR_ADR_ID: v = PART_REV;
			`OSR_ADR_UNUSED: v = 8'h00;
			`OSR_ADR_LED: v = {TRIM_TAG, st.led_code};
			default:
				if (a >= `OSR_ADR_BASE && a <= `OSR_ADR_LAST)
				begin
					v = st.store[a[3:0]];
				end
		endcase
		return v;
	endfunction

	// Bus line events, from the previous sampled levels
	assign rise = scl_i & ~s.scl_q;
	assign fall = ~scl_i & s.scl_q;
	assign start_c = s.scl_q & scl_i & s.sda_q & ~sda_i;
	assign stop_c = s.scl_q & scl_i & ~s.sda_q & sda_i;

	// Fixed read views, watched by checks below
	assign cmd_rd = rd_byte(`OSR_ADR_CMD, s);
	assign id_rd = rd_byte(`OSR_ADR_ID, s);
	assign unused_rd = rd_byte(`OSR_ADR_UNUSED, s);
	assign led_rd = rd_byte(`OSR_ADR_LED, s);

	// Next state; oversampling keeps up with 3.4 MHz bus clock
	always_comb
	begin
		n = s;
		wr_en = 1'b0;
		rd_ld = 1'b0;
		rd = 8'h00;
		if (ce_i)
		begin
			n.scl_q = scl_i;
			n.sda_q = sda_i;
			n.lstart = 1'b0;
			n.nstart = 1'b0;
			unique case (s.st)
				osr_pkg::ST_IDLE: n.oe = 1'b0;
				osr_pkg::ST_RX:
					if (rise)
					begin
						n.sh = {s.sh[6:0], sda_i};
						n.cnt = s.cnt + 4'h1;
					end
					else if (fall && s.cnt == 4'h8)
					begin
						n.cnt = 4'h0;
						n.st = osr_pkg::ST_ACK;
						n.oe = 1'b1;
						unique case (s.ph)
							osr_pkg::PH_ADDR:
								if (s.sh[7:1] == `OSR_BUS_ADDR)
								begin
									n.rw = s.sh[0];
								end
								else
								begin
									n.st = osr_pkg::ST_IDLE;
									n.oe = 1'b0;
								end
							osr_pkg::PH_REG: n.ptr = s.sh;
							default:
							begin
								wr_en = 1'b1;
								n.ptr = s.ptr + 8'h01;
							end
						endcase
					end
				osr_pkg::ST_ACK:
					if (fall)
					begin
						n.oe = 1'b0;
						if (s.ph == osr_pkg::PH_ADDR && s.rw)
						begin
							rd_ld = 1'b1;
						end
						else
						begin
							n.st = osr_pkg::ST_RX;
							n.ph = (s.ph == osr_pkg::PH_ADDR) ? osr_pkg::PH_REG : osr_pkg::PH_DATA;
						end
					end
				osr_pkg::ST_TX:
					if (fall)
					begin
						if (s.cnt == 4'h7)
						begin
							n.st = osr_pkg::ST_MACK;
							n.oe = 1'b0;
							n.cnt = 4'h0;
						end
						else
						begin
							n.sh = {s.sh[6:0], 1'b0};
							n.cnt = s.cnt + 4'h1;
							n.oe = ~s.sh[6];
						end
					end
				osr_pkg::ST_MACK:
					// Host not-acknowledge ends the read
					if (rise && sda_i)
					begin
						n.st = osr_pkg::ST_IDLE;
					end
					else if (fall)
					begin
						rd_ld = 1'b1;
					end
				default: n.st = osr_pkg::ST_IDLE;
			endcase
			// Load next read byte; reading a low result byte clears its flag
			if (rd_ld)
			begin
				rd = rd_byte(s.ptr, s);
				n.sh = rd;
				n.oe = ~rd[7];
				n.cnt = 4'h0;
				n.st = osr_pkg::ST_TX;
				n.ptr = s.ptr + 8'h01;
				if (s.ptr == `OSR_ADR_LIGHT_LO)
				begin
					n.lrdy = 1'b0;
				end
				if (s.ptr == `OSR_ADR_NEAR_LO)
				begin
					n.nrdy = 1'b0;
				end
			end
			// Register writes; results, id and 82h ignore writes
			if (wr_en)
			begin
				if (s.ptr == `OSR_ADR_CMD)
				begin
					n.lstart = s.sh[`OSR_CMD_LSTART];
					n.nstart = s.sh[`OSR_CMD_NSTART];
				end
				else if (s.ptr == `OSR_ADR_LED)
				begin
					n.led_code = s.sh[5:0];
				end
				else if (s.ptr == `OSR_ADR_LPARAM || (s.ptr >= `OSR_ADR_SPARE && s.ptr <= `OSR_ADR_LAST))
				begin
					n.store[s.ptr[3:0]] = s.sh;
				end
			end
			// Completion comes after the read clear so a set wins over it
			if (light_done_i)
			begin
				n.store[4'h5] = light_data_i[15:8];
				n.store[4'h6] = light_data_i[7:0];
				n.lrdy = 1'b1;
			end
			if (near_done_i)
			begin
				n.store[4'h7] = near_data_i[15:8];
				n.store[4'h8] = near_data_i[7:0];
				n.nrdy = 1'b1;
			end
			// Bus start and stop override any byte in flight
			if (start_c)
			begin
				n.st = osr_pkg::ST_RX;
				n.ph = osr_pkg::PH_ADDR;
				n.cnt = 4'h0;
				n.oe = 1'b0;
			end
			else if (stop_c)
			begin
				n.st = osr_pkg::ST_IDLE;
				n.oe = 1'b0;
			end
			// Clamp keeps the drive at 200 mA for codes above 20
			n.led_drive = (n.led_code > `OSR_LED_MAX) ? `OSR_LED_MAX : n.led_code;
		end
	end

	// State register
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			s <= '0;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
			s.led_code <= `OSR_LED_RESET;
			s.led_drive <= `OSR_LED_RESET;
		end
		else
		begin
			s <= n;
		end
	end

	// Open-drain data line: only ever pulled low
	assign sda_o = 1'b0;
	assign sda_oe_o = s.oe;
	assign light_single_shot_o = s.lstart;
	assign near_single_shot_o = s.nstart;
	assign led_drive_o = s.led_drive;
	assign light_param_o = s.store[4'h4];

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence addr_byte_done;
		ce_i && fall && s.st == osr_pkg::ST_RX && s.cnt == 4'h8 && s.ph == osr_pkg::PH_ADDR;
	endsequence

	sequence bus_stop;
		ce_i && stop_c && !start_c;
	endsequence

	sequence both_starts_written;
		ce_i && wr_en && s.ptr == `OSR_ADR_CMD && s.sh[4:3] == 2'b11;
	endsequence

	addr_reject_a: assert property (addr_byte_done ##0 (s.sh[7:1] != `OSR_BUS_ADDR) |=>
		s.st == osr_pkg::ST_IDLE && !sda_oe_o) else $error("Foreign address acknowledged");
	addr_accept_a: assert property (addr_byte_done ##0 (s.sh[7:1] == `OSR_BUS_ADDR) |=>
		sda_oe_o && s.rw == $past(s.sh[0])) else $error("Own address not acknowledged");
	stop_idle_a: assert property (bus_stop |=> s.st == osr_pkg::ST_IDLE && !sda_oe_o)
		else $error("Stop did not release the bus");
	cmd_view_a: assert property (cmd_rd[7] && cmd_rd[4:0] == 5'h00)
		else $error("Command byte read view wrong");
	cmd_load_a: assert property (ce_i && rd_ld && s.ptr == `OSR_ADR_CMD |=>
		s.sh == {1'b1, $past(s.lrdy), $past(s.nrdy), 5'h00} && !sda_oe_o)
		else $error("Command byte loaded wrong");
	both_start_a: assert property (both_starts_written |=> light_single_shot_o && near_single_shot_o ##1
		!light_single_shot_o && !near_single_shot_o) else $error("Joint start not one pulse");
	light_ready_a: assert property (ce_i && light_done_i |=> s.lrdy &&
		{s.store[4'h5], s.store[4'h6]} == $past(light_data_i)) else $error("Light result not latched");
	near_ready_a: assert property (ce_i && near_done_i |=> s.nrdy &&
		{s.store[4'h7], s.store[4'h8]} == $past(near_data_i)) else $error("Near result not latched");
	near_clear_a: assert property (ce_i && rd_ld && s.ptr == `OSR_ADR_NEAR_LO && !near_done_i |=> !s.nrdy)
		else $error("Near flag not cleared by read");
	id_fixed_a: assert property (id_rd == PART_REV && unused_rd == 8'h00)
		else $error("Id or unused register wrong");
	led_clamp_a: assert property (led_drive_o <= `OSR_LED_MAX && led_rd[7:6] == TRIM_TAG)
		else $error("Emitter drive above limit");
	led_write_a: assert property (ce_i && wr_en && s.ptr == `OSR_ADR_LED |=> ##1
		led_drive_o == (($past(s.sh[5:0], 2) > `OSR_LED_MAX) ? `OSR_LED_MAX : $past(s.sh[5:0], 2)))
		else $error("Emitter code write lost");

endmodule // osr_regs

// [osr_cfg.svh]
`ifndef OSR_CFG_SVH
`define OSR_CFG_SVH

// Fixed 7-bit bus address
`define OSR_BUS_ADDR 7'h13

// Register addresses
`define OSR_ADR_BASE 8'h80
`define OSR_ADR_CMD 8'h80
`define OSR_ADR_ID 8'h81
`define OSR_ADR_UNUSED 8'h82
`define OSR_ADR_LED 8'h83
`define OSR_ADR_LPARAM 8'h84
`define OSR_ADR_LIGHT_HI 8'h85
`define OSR_ADR_LIGHT_LO 8'h86
`define OSR_ADR_NEAR_HI 8'h87
`define OSR_ADR_NEAR_LO 8'h88
`define OSR_ADR_SPARE 8'h89
`define OSR_ADR_LAST 8'h8B

// Command register fields
`define OSR_CMD_LOCK 7
`define OSR_CMD_LRDY 6
`define OSR_CMD_NRDY 5
`define OSR_CMD_LSTART 4
`define OSR_CMD_NSTART 3

// Emitter current code, one step is 10 mA
`define OSR_LED_STEP_MA 10
`define OSR_LED_RESET 6'h02
`define OSR_LED_MAX 6'h14

`endif

// [osr_pkg.sv]
package osr_pkg;

	// Bus slave states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_MACK = 3'b100
	} osr_st_e;

	// Which byte of a transfer is being received
	typedef enum logic [1:0] {
		PH_ADDR = 2'b00,
		PH_REG = 2'b01,
		PH_DATA = 2'b10
	} osr_ph_e;

	typedef struct packed {
		osr_st_e st;
		osr_ph_e ph;
		logic scl_q;
		logic sda_q;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rw;
		logic [7:0] ptr;
		logic oe;
		logic lrdy;
		logic nrdy;
		logic lstart;
		logic nstart;
		logic [5:0] led_code;
		logic [5:0] led_drive;
		logic [11:0][7:0] store;
	} osr_state_s;

endpackage

// [osr_host.sv]
`timescale 1ns/1ns
// Bus host model: makes the bus clock and only ever pulls data low or lets it go
module osr_host (
	input wire logic sys_clk_i, // System clock
	input wire logic sda_i, // Resolved data wire
	output logic scl_o, // Bus clock
	output logic sda_o // Data drive, 1 lets go
);
	int nak_cnt = 0;
	// Bus idle at time zero
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Three cycles a phase, above the two-cycle minimum of each clock phase
	task automatic hw();
		repeat (3) @(posedge sys_clk_i);
	endtask
	// One bit: data set while clock low, sampled just before the clock falls, on a settled wire
	task automatic bit_io(input logic b, output logic r);
		sda_o <= b;
		hw();
		scl_o <= 1'b1;
		hw();
		@(negedge sys_clk_i) r = sda_i;
		@(posedge sys_clk_i) scl_o <= 1'b0;
		hw();
	endtask
	task automatic start();
		sda_o <= 1'b1;
		hw();
		scl_o <= 1'b1;
		hw();
		sda_o <= 1'b0;
		hw();
		scl_o <= 1'b0;
		hw();
	endtask
	task automatic stop();
		sda_o <= 1'b0;
		hw();
		scl_o <= 1'b1;
		hw();
		sda_o <= 1'b1;
		hw();
	endtask
	// Sends a byte MSB first; a missing acknowledge is counted
	task automatic put(input logic [7:0] d);
		logic [7:0] q;
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(1'b1, r);
		if (r)
			nak_cnt++;
	endtask
	task automatic get(input logic last, output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, q[i]);
		bit_io(last, r);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		start();
		put(8'h26);
		put(a);
		put(d);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		start();
		put(8'h26);
		put(a);
		start();
		put(8'h27);
		get(1'b1, q);
		stop();
	endtask
endmodule // osr_host

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
	localparam logic [7:0] PR = 8'h5a; // Arbitrary id value
	localparam logic [1:0] TT = 2'h2; // Arbitrary trim tag
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic ld = 1'b0;
	logic nd = 1'b0;
	logic [15:0] lv = 16'h0000;
	logic [15:0] nv = 16'h0000;
	logic scl, hsda, sda_o, sda_oe, lss, nss;
	logic [5:0] led;
	logic [7:0] lp, q;
	// Pull-up wire: low when either side pulls
	wire sda = hsda & (sda_oe ? sda_o : 1'b1);
	int miscompares = 0, n_tests = 0, seed = 32'he59a, lr = 0, nr = 0, nl = 0, nn = 0, el = 0, en = 0;
	int m[13] = '{3: 2, default: 0}; // Emitter code resets to 2
	int seq[9] = '{0, 5, 0, 6, 0, 7, 0, 8, 0};
	logic [7:0] codes[4] = '{8'h00, 8'h14, 8'h15, 8'hff};
	always #10 sys_clk = ~sys_clk;
	osr_regs #(.PART_REV(PR), .TRIM_TAG(TT)) u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .light_done_i(ld),
		.light_data_i(lv), .near_done_i(nd), .near_data_i(nv), .light_single_shot_o(lss),
		.near_single_shot_o(nss), .led_drive_o(led), .light_param_o(lp));
	osr_host u_host (.sys_clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
	// Counting high cycles also catches a pulse that stretches
	always @(posedge sys_clk)
	begin
		if (!rst)
		begin
			nl += lss;
			nn += nss;
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Model read, with the flag clear that a low result byte brings
	function automatic logic [7:0] ev(input int a);
		logic [7:0] v;
		case (a)
			0: v = {1'b1, lr[0], nr[0], 5'h00};
			1: v = PR;
			3: v = {TT, 6'(m[3])};
			default: v = 8'(m[a]);
		endcase
		if (a == 6)
			lr = 0;
		if (a == 8)
			nr = 0;
		return v;
	endfunction
	task automatic w(input int a, input logic [7:0] d);
		u_host.wr(8'(8'h80 + a), d);
		if (a == 0)
		begin
			el += d[4];
			en += d[3];
		end
		if (a == 3 || a == 4 || (a > 8 && a < 12))
			m[a] = d;
	endtask
	task automatic r(input int a);
		logic [7:0] e;
		e = ev(a);
		u_host.rd(8'(8'h80 + a), q);
		chk(q, e);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk(8'(led), 8'h02);
		for (int a = 0; a < 5; a++)
			r(a);
		// Random fill of the map and one place past its end
		for (int a = 0; a < 13; a++)
			w(a, 8'($random(seed)));
		for (int a = 0; a < 13; a++)
			r(a);
		chk(lp, 8'(m[4]));
		w(0, 8'h18);
		chk(8'(nl), 8'(el));
		chk(8'(nn), 8'(en));
		r(0);
		repeat (20000) @(posedge sys_clk);
		lv <= 16'($random(seed));
		nv <= 16'($random(seed));
		ld <= 1'b1;
		nd <= 1'b1;
		@(posedge sys_clk);
		ld <= 1'b0;
		nd <= 1'b0;
		lr = 1;
		nr = 1;
		m[5] = lv[15:8];
		m[6] = lv[7:0];
		m[7] = nv[15:8];
		m[8] = nv[7:0];
		foreach (seq[i])
			r(seq[i]);
		// Emitter codes at, past and far past the limit, top bits written too
		foreach (codes[i])
		begin
			w(3, codes[i]);
			chk(8'(led), (codes[i][5:0] > 6'h14) ? 8'h14 : 8'(codes[i][5:0]));
			r(3);
		end
		// A done pulse while the clock enable is low must be lost
		ce <= 1'b0;
		lv <= 16'($random(seed));
		ld <= 1'b1;
		@(posedge sys_clk);
		ld <= 1'b0;
		@(posedge sys_clk);
		ce <= 1'b1;
		r(0);
		r(6);
		// Other bus addresses must never be acknowledged
		u_host.start();
		u_host.put(8'h28);
		u_host.stop();
		u_host.start();
		u_host.put(8'h29);
		u_host.stop();
		r(1);
		chk(8'(u_host.nak_cnt), 8'h02);
		end_of_test();
	end
	// Watchdog, well beyond the expected run length
	initial
	begin
		#1200000;
		miscompares++;
		end_of_test();
	end
endmodule // testbench
